// ---- rtl/civ_core.sv ----
// Purpose: interrupt priority, stacking and vector fetch sequencer
// Assumes: memory answers a read in the same cycle its strobe is high
// Notes: core holds while stall_o is high; loads pc/sp on the pulses

module civ_core (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic reset_pin_n_i,
  input wire logic boundary_i,
  input wire logic swi_exec_i,
  input wire logic rti_exec_i,
  input wire logic cli_i,
  input wire logic sei_i,
  input wire civ_pkg::civ_regs_s cpu_regs_i,
  input wire logic [15:0] sp_i,
  input wire civ_pkg::civ_periph_s periph_i,
  input wire logic [7:0] core_count_i,
  input wire logic periodic_tick_i,
  input wire logic core_overflow_enable_i,
  input wire logic periodic_int_enable_i,
  input wire logic core_ovf_clr_i,
  input wire logic periodic_int_clr_i,
  input wire logic irq_pin_n_i,
  input wire logic irq_level_mode_i,
  input wire logic [7:0] mem_rdata_i,
  output logic stall_o,
  output logic int_mask_o,
  output civ_pkg::civ_mem_s mem_o,
  output logic pc_load_o,
  output logic restore_o,
  output civ_pkg::civ_regs_s regs_o,
  output logic [15:0] sp_o,
  output logic irq_pin_level_o,
  output logic core_ovf_flag_o,
  output logic periodic_int_flag_o
);
  import civ_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    civ_state_e st;
    logic imask;
    logic software_trap_instr;
    logic [2:0] cnt;
    logic [15:0] sp;
    logic [15:0] vec;
    logic [7:0] hi;
    logic [NUM_HW_SRC-1:0] snap;
    civ_regs_s regs;
    civ_mem_s mem;
    logic pc_load;
    logic restore;
    logic ext_ack;
    logic [7:0] ct_prev;
    logic ct_ovf;
    logic ct_per;
  } civ_core_s;

  // Reset parks on the reset vector read with the mask set
  localparam civ_core_s RESET_STATE = '{
    st: CIV_VEC_HI, imask: 1'b1, software_trap_instr: 1'b0, cnt: '0, sp: '0,
    vec: VEC_RESET, hi: '0, snap: '0, regs: '0,
    mem: '{addr: VEC_RESET, rd: 1'b1, wr: 1'b0, wdata: '0},
    pc_load: 1'b0, restore: 1'b0, ext_ack: 1'b0,
    ct_prev: '0, ct_ovf: 1'b0, ct_per: 1'b0};

  civ_core_s s;
  civ_core_s next_s;
  logic ext_req;
  logic [NUM_HW_SRC-1:0] req;
  logic take_hw;
  logic take_any;

  // ****************************************
  // Helpers
  // ****************************************
  // One source line: any flag with its local enable
  function automatic logic any_enabled(input logic [7:0] f, input logic [7:0] e);
    return |(f & e);
  endfunction : any_enabled

  // Fixed priority, highest vector address first
  function automatic logic [15:0] prio_vector(input logic [NUM_HW_SRC-1:0] r);
    logic [15:0] v;
    v = VEC_SCI;
    if (r[SRC_EXT]) v = VEC_EXT;
    else if (r[SRC_CT]) v = VEC_CT;
    else if (r[SRC_T1]) v = VEC_T1;
    else if (r[SRC_T2]) v = VEC_T2;
    else if (r[SRC_SPI]) v = VEC_SPI;
    return v;
  endfunction : prio_vector

  // Stack frame byte by push index
  function automatic logic [7:0] frame_byte(input civ_regs_s r, input logic [2:0] i);
    logic [7:0] b;
    case (i)
      PUSH_PCL: b = r.pc[7:0];
      PUSH_PCH: b = r.pc[15:8];
      PUSH_X: b = r.x;
      PUSH_A: b = r.a;
      default: b = r.condition_code_register;
    endcase
    return b;
  endfunction : frame_byte

  // Write one popped byte back by push index
  function automatic civ_regs_s frame_store(input civ_regs_s r, input logic [2:0] i,
                                            input logic [7:0] d);
    civ_regs_s o;
    o = r;
    case (i)
      PUSH_PCL: o.pc[7:0] = d;
      PUSH_PCH: o.pc[15:8] = d;
      PUSH_X: o.x = d;
      PUSH_A: o.a = d;
      default: o.condition_code_register = d;
    endcase
    return o;
  endfunction : frame_store

  // ****************************************
  // External request latch
  // ****************************************
  civ_ext_latch u_ext_latch (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .irq_pin_n_i(irq_pin_n_i),
    .level_mode_i(irq_level_mode_i),
    .ack_i(s.ext_ack),
    .req_o(ext_req),
    .pin_level_o(irq_pin_level_o)
  );

  // ****************************************
  // Source request lines
  // ****************************************
  // Keyboard wakeup joins the pin request on one line
  always_comb begin
    req = '0;
    req[SRC_EXT] = ext_req | any_enabled(periph_i.kbd_flag,
                                         periph_i.keyboard_wakeup_enable);
    req[SRC_CT] = (s.ct_ovf & core_overflow_enable_i)
                | (s.ct_per & periodic_int_enable_i);
    req[SRC_T1] = any_enabled({5'h0, periph_i.t1_flag}, {5'h0, periph_i.t1_en});
    req[SRC_T2] = any_enabled({5'h0, periph_i.t2_flag}, {5'h0, periph_i.t2_en});
    req[SRC_SPI] = any_enabled({6'h0, periph_i.spi_flag}, {6'h0, {2{periph_i.spi_en}}});
    req[SRC_SCI] = any_enabled({3'h0, periph_i.sci_flag}, {3'h0, periph_i.sci_en});
  end

  // Hardware entry only at a boundary with the mask clear
  assign take_hw = boundary_i & ~s.imask & (|req);
  assign take_any = (s.st == CIV_RUN) & (swi_exec_i | rti_exec_i | take_hw);

  // ****************************************
  // Sequencer next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.mem.rd = 1'b0;
    next_s.mem.wr = 1'b0;
    next_s.pc_load = 1'b0;
    next_s.restore = 1'b0;
    next_s.ext_ack = 1'b0;
    // Core timer flags: a new event beats a clear in the same cycle
    next_s.ct_prev = core_count_i;
    if (s.ct_prev == CT_TOP && core_count_i == CT_WRAP) begin
      next_s.ct_ovf = 1'b1;
    end else if (core_ovf_clr_i) begin
      next_s.ct_ovf = 1'b0;
    end
    if (periodic_tick_i) begin
      next_s.ct_per = 1'b1;
    end else if (periodic_int_clr_i) begin
      next_s.ct_per = 1'b0;
    end
    case (s.st)
      CIV_RUN: begin
        if (cli_i) begin
          next_s.imask = 1'b0;
        end else if (sei_i) begin
          next_s.imask = 1'b1;
        end
        if (swi_exec_i || take_hw) begin
          // Trap runs as its own instruction, so anything pending
          // before its fetch was already taken at the prior boundary
          next_s.software_trap_instr = swi_exec_i;
          next_s.snap = req;
          next_s.regs = cpu_regs_i;
          next_s.regs.condition_code_register[CCR_I_BIT] = s.imask;
          next_s.sp = sp_i;
          next_s.cnt = PUSH_PCL;
          next_s.mem.addr = sp_i;
          next_s.mem.wr = 1'b1;
          next_s.mem.wdata = frame_byte(cpu_regs_i, PUSH_PCL);
          next_s.st = CIV_PUSH;
        end else if (rti_exec_i) begin
          next_s.sp = sp_i + ADDR_STEP;
          next_s.cnt = '0;
          next_s.mem.addr = sp_i + ADDR_STEP;
          next_s.mem.rd = 1'b1;
          next_s.st = CIV_POP;
        end
      end
      CIV_PUSH: begin
        next_s.sp = s.sp - ADDR_STEP;
        if (s.cnt == STACK_LAST) begin
          next_s.imask = 1'b1;
          next_s.st = CIV_VSEL;
        end else begin
          next_s.cnt = s.cnt + CNT_STEP;
          next_s.mem.addr = s.sp - ADDR_STEP;
          next_s.mem.wr = 1'b1;
          next_s.mem.wdata = frame_byte(s.regs, s.cnt + CNT_STEP);
        end
      end
      CIV_VSEL: begin
        // Pick the source only after stacking; fall back to the
        // entry snapshot if the request went away meanwhile
        if (s.software_trap_instr) begin
          next_s.vec = VEC_SWI;
        end else if (|req) begin
          next_s.vec = prio_vector(req);
        end else begin
          next_s.vec = prio_vector(s.snap);
        end
        next_s.ext_ack = ~s.software_trap_instr & ((|req) ? req[SRC_EXT] : s.snap[SRC_EXT]);
        next_s.mem.addr = next_s.vec;
        next_s.mem.rd = 1'b1;
        next_s.st = CIV_VEC_HI;
      end
      CIV_VEC_HI: begin
        next_s.hi = mem_rdata_i;
        next_s.mem.addr = s.vec + ADDR_STEP;
        next_s.mem.rd = 1'b1;
        next_s.st = CIV_VEC_LO;
      end
      CIV_VEC_LO: begin
        next_s.regs.pc = {s.hi, mem_rdata_i};
        next_s.pc_load = 1'b1;
        next_s.st = CIV_RUN;
      end
      CIV_POP: begin
        next_s.regs = frame_store(s.regs, STACK_LAST - s.cnt, mem_rdata_i);
        if (s.cnt == STACK_LAST) begin
          next_s.imask = s.regs.condition_code_register[CCR_I_BIT];
          next_s.restore = 1'b1;
          next_s.st = CIV_RUN;
        end else begin
          next_s.cnt = s.cnt + CNT_STEP;
          next_s.sp = s.sp + ADDR_STEP;
          next_s.mem.addr = s.sp + ADDR_STEP;
          next_s.mem.rd = 1'b1;
        end
      end
      default: begin
        next_s.st = CIV_RUN;
      end
    endcase
    // Pin reset halts at once, unlike ordinary requests
    if (!reset_pin_n_i) begin
      next_s = RESET_STATE;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Stall also covers the cycle in which entry is decided
  assign stall_o = (s.st != CIV_RUN) | take_any;
  assign int_mask_o = s.imask;
  assign mem_o = s.mem;
  assign pc_load_o = s.pc_load;
  assign restore_o = s.restore;
  assign regs_o = s.regs;
  assign sp_o = s.sp;
  assign core_ovf_flag_o = s.ct_ovf;
  assign periodic_int_flag_o = s.ct_per;

endmodule : civ_core

// ---- shared/civ_pkg.sv ----
// Purpose: shared constants and types for the interrupt sequencing block
// Assumes: 16-bit address space, byte-wide memory port
// Notes: vector slots are big-endian byte pairs at the top of memory

package civ_pkg;

  // ****************************************
  // Vector table
  // ****************************************
  localparam logic [15:0] VEC_SCI = 16'h3ff0;
  localparam logic [15:0] VEC_SPI = 16'h3ff2;
  localparam logic [15:0] VEC_T2 = 16'h3ff4;
  localparam logic [15:0] VEC_T1 = 16'h3ff6;
  localparam logic [15:0] VEC_CT = 16'h3ff8;
  localparam logic [15:0] VEC_EXT = 16'h3ffa;
  localparam logic [15:0] VEC_SWI = 16'h3ffc;
  localparam logic [15:0] VEC_RESET = 16'h3ffe;
  localparam logic [15:0] ADDR_STEP = 16'h0001;

  // ****************************************
  // Hardware source indices, highest priority first
  // ****************************************
  localparam int SRC_EXT = 0;
  localparam int SRC_CT = 1;
  localparam int SRC_T1 = 2;
  localparam int SRC_T2 = 3;
  localparam int SRC_SPI = 4;
  localparam int SRC_SCI = 5;
  localparam int NUM_HW_SRC = 6;

  // ****************************************
  // Core timer, stack frame, condition codes
  // ****************************************
  localparam logic [7:0] CT_TOP = 8'hff;
  localparam logic [7:0] CT_WRAP = 8'h00;
  localparam logic [2:0] PUSH_PCL = 3'h0;
  localparam logic [2:0] PUSH_PCH = 3'h1;
  localparam logic [2:0] PUSH_X = 3'h2;
  localparam logic [2:0] PUSH_A = 3'h3;
  localparam logic [2:0] PUSH_CCR = 3'h4;
  localparam logic [2:0] STACK_LAST = 3'h4;
  localparam logic [2:0] CNT_STEP = 3'h1;
  localparam int CCR_I_BIT = 3;
  localparam int ENTRY_OVERHEAD_CYC = 10;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    CIV_RUN, CIV_PUSH, CIV_VSEL, CIV_VEC_HI, CIV_VEC_LO, CIV_POP
  } civ_state_e;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] x;
    logic [7:0] a;
    logic [7:0] condition_code_register;
  } civ_regs_s;

  typedef struct packed {
    logic [2:0] t1_flag;
    logic [2:0] t1_en;
    logic [2:0] t2_flag;
    logic [2:0] t2_en;
    logic [1:0] spi_flag;
    logic spi_en;
    logic [4:0] sci_flag;
    logic [4:0] sci_en;
    logic [7:0] kbd_flag;
    logic [7:0] keyboard_wakeup_enable;
  } civ_periph_s;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } civ_mem_s;

endpackage : civ_pkg

// ---- rtl/civ_ext_latch.sv ----
// Purpose: external request pin synchroniser and falling-edge latch
// Assumes: pin idles high; ack is a one-cycle pulse from the sequencer
// Notes: level mode adds the synchronised low level to the latch

module civ_ext_latch (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic irq_pin_n_i,
  input wire logic level_mode_i,
  input wire logic ack_i,
  output logic req_o,
  output logic pin_level_o
);
  import civ_pkg::*;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic latched;
  } civ_latch_s;

  civ_latch_s s;
  civ_latch_s next_s;

  // ****************************************
  // Next state
  // ****************************************
  // Edge detector looks only at the second stage, never the first
  always_comb begin
    next_s = s;
    next_s.sync1 = irq_pin_n_i;
    next_s.sync2 = s.sync1;
    next_s.prev = s.sync2;
    if (s.prev && !s.sync2) begin
      next_s.latched = 1'b1;
    end else if (ack_i) begin
      next_s.latched = 1'b0;
    end
  end

  // Pin idles high so the chain resets high to avoid a false edge
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      s <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, latched: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // Level term keeps asserting while pin is held low
  assign req_o = s.latched | (level_mode_i & ~s.sync2);
  assign pin_level_o = s.sync2;

endmodule : civ_ext_latch

// ---- verification/civ_core_checker.sv ----
// Purpose: port checks for the interrupt sequencer
// Assumes: strobes are only pulsed while the core runs
// Notes: bound to civ_core from the testbench
module civ_core_checker (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic boundary_i,
  input wire logic swi_exec_i,
  input wire logic rti_exec_i,
  input wire logic [15:0] sp_i,
  input wire logic irq_pin_n_i,
  input wire logic stall_o,
  input wire logic int_mask_o,
  input wire civ_pkg::civ_mem_s mem_o,
  input wire logic pc_load_o,
  input wire logic restore_o,
  input wire civ_pkg::civ_regs_s regs_o,
  input wire logic [15:0] sp_o,
  input wire logic irq_pin_level_o
);
  import civ_pkg::*;
  // ****************
  // Sequence checks
  // ****************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  chk_trap_latency: assert property (swi_exec_i |-> ##9 pc_load_o)
    else $error("trap entry load late");
  chk_trap_mask: assert property (swi_exec_i |-> ##6 int_mask_o)
    else $error("mask not set during entry");
  chk_push_first: assert property (swi_exec_i |=> mem_o.wr && mem_o.addr == $past(sp_i))
    else $error("first push not at stack pointer");
  chk_entry_sp: assert property (swi_exec_i |-> ##9 sp_o == $past(sp_i, 9) - 16'h0005)
    else $error("entry stack pointer wrong");
  chk_return_time: assert property (rti_exec_i && !swi_exec_i && !boundary_i |-> ##6 restore_o)
    else $error("return not done in six cycles");
  chk_return_mask: assert property (restore_o |-> int_mask_o == regs_o.condition_code_register[CCR_I_BIT])
    else $error("mask not restored");
  chk_reset_load: assert property ($fell(sys_rst_i) |-> ##2 pc_load_o && int_mask_o)
    else $error("reset vector load missing");
  chk_mask_refuse: assert property (boundary_i && int_mask_o && !swi_exec_i && !rti_exec_i |-> !stall_o)
    else $error("masked request taken");
  chk_pin_sync: assert property ($fell(irq_pin_n_i) |-> ##1 irq_pin_level_o ##1 !irq_pin_level_o)
    else $error("pin level timing wrong");
endmodule : civ_core_checker

// ---- verification/civ_mem_model.sv ----
// Purpose: byte memory behind the sequencer
// Assumes: reads answered in the strobe cycle
// Notes: vector byte is its address xor a5
module civ_mem_model (
  input wire logic clock_i,
  input wire civ_pkg::civ_mem_s mem_i,
  output logic [7:0] rdata_o
);
  import civ_pkg::*;
  logic [7:0] stk [256];
  logic [7:0] last;
  // ****************
  // Storage
  // ****************
  // Stack page writes, last read kept for idle bus
  always_ff @(posedge clock_i) begin
    if (mem_i.wr) begin
      stk[mem_i.addr[7:0]] <= mem_i.wdata;
    end
    if (mem_i.rd) begin
      last <= rdata_o;
    end
  end
  // Idle bus shows inverse so stale data cannot pass
  always_comb begin
    if (!mem_i.rd) begin
      rdata_o = ~last;
    end else if (mem_i.addr >= VEC_SCI) begin
      rdata_o = mem_i.addr[7:0] ^ 8'ha5;
    end else begin
      rdata_o = stk[mem_i.addr[7:0]];
    end
  end
endmodule : civ_mem_model

// ---- verification/cpu_interrupt_priority_vectoring_test.sv ----
// Purpose: directed bench for civ_core
// Assumes: memory model answers reads at once
// Notes: inputs change 10 ns after the rising edge
module cpu_interrupt_priority_vectoring_test;
  timeunit 1ns;
  timeprecision 1ns;
  import civ_pkg::*;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic bnd = 1'b0, software_trap_instr = 1'b0, return_from_interrupt_instr = 1'b0, cli = 1'b0, sei = 1'b0;
  logic tick_p = 1'b0, ovf_en = 1'b0, per_en = 1'b0, ovf_clr = 1'b0, per_clr = 1'b0;
  logic irq_n = 1'b1, lvl = 1'b0, stall, mask, load, rest, pin_lvl, ovf_f, per_f;
  logic rst_pin_n = 1'b1;
  logic [7:0] cnt = 8'h00, rdata;
  logic [15:0] sp = 16'h00ff, sp_o;
  civ_regs_s regs = '0, regs_o;
  civ_periph_s per = '0;
  civ_mem_s mem;
  int bad_count = 0, n_compared = 0, cycles = 0;
  // ****************
  // Harness
  // ****************
  always #50 clock_i = ~clock_i;
  civ_core u_civ_core (.clock_i, .sys_rst_i, .reset_pin_n_i(rst_pin_n), .boundary_i(bnd),
    .swi_exec_i(software_trap_instr), .rti_exec_i(return_from_interrupt_instr), .cli_i(cli), .sei_i(sei), .cpu_regs_i(regs),
    .sp_i(sp), .periph_i(per), .core_count_i(cnt), .periodic_tick_i(tick_p),
    .core_overflow_enable_i(ovf_en), .periodic_int_enable_i(per_en),
    .core_ovf_clr_i(ovf_clr), .periodic_int_clr_i(per_clr), .irq_pin_n_i(irq_n),
    .irq_level_mode_i(lvl), .mem_rdata_i(rdata), .stall_o(stall), .int_mask_o(mask),
    .mem_o(mem), .pc_load_o(load), .restore_o(rest), .regs_o(regs_o), .sp_o(sp_o),
    .irq_pin_level_o(pin_lvl), .core_ovf_flag_o(ovf_f), .periodic_int_flag_o(per_f));
  civ_mem_model u_civ_mem_model (.clock_i, .mem_i(mem), .rdata_o(rdata));
  task automatic tick();
    @(posedge clock_i);
    #10;
  endtask : tick
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Expected address from a big-endian slot
  function automatic logic [15:0] vpc(logic [15:0] v);
    return {v[7:0] ^ 8'ha5, (v[7:0] + 8'h01) ^ 8'ha5};
  endfunction : vpc
  // One-cycle mask strobe: 0 clears, 1 sets
  task automatic strobe(input int k);
    cli = (k == 0);
    sei = (k == 1);
    tick();
    cli = 1'b0;
    sei = 1'b0;
  endtask : strobe
  // Pulse boundary, trap or return; count edges to the answer
  task automatic go(input int kind, output int n);
    bnd = (kind == 0);
    software_trap_instr = (kind == 1);
    return_from_interrupt_instr = (kind == 2);
    tick();
    bnd = 1'b0;
    software_trap_instr = 1'b0;
    return_from_interrupt_instr = 1'b0;
    // Count includes the edge that took the request
    n = 1;
    while (((kind == 2) ? rest : load) !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
  endtask : go
  task automatic conclude();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  // Hang guard
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      conclude();
    end
  end
  // ****************
  // Scenarios
  // ****************
  task automatic t_trap(input logic m);
    int n;
    regs = '{pc: 16'h1234, x: 8'h56, a: 8'h78, condition_code_register: 8'h00};
    sp = 16'h00ff;
    go(1, n);
    check("trap time", 16'(n), 16'h0009);
    check("trap pc", regs_o.pc, vpc(VEC_SWI));
    check("trap sp", sp_o, 16'h00fa);
    check("trap mask", mask, 1'b1);
    check("push pc", {u_civ_mem_model.stk[254], u_civ_mem_model.stk[255]}, 16'h1234);
    check("push xa", {u_civ_mem_model.stk[253], u_civ_mem_model.stk[252]}, 16'h5678);
    check("push ccr", u_civ_mem_model.stk[251], {4'h0, m, 3'h0});
    regs = '0;
    sp = 16'h00fa;
    go(2, n);
    check("ret time", 16'(n), 16'h0006);
    check("ret pc", regs_o.pc, 16'h1234);
    check("ret xa", {regs_o.x, regs_o.a}, 16'h5678);
    check("ret sp", sp_o, 16'h00ff);
    check("ret mask", mask, m);
  endtask : t_trap
  task automatic t_refuse();
    strobe(1);
    check("sei", mask, 1'b1);
    per.t1_flag = 3'b001;
    per.t1_en = 3'b001;
    bnd = 1'b1;
    #1;
    check("masked", stall, 1'b0);
    tick();
    bnd = 1'b0;
    per.t1_flag = 3'b010;
    strobe(0);
    bnd = 1'b1;
    #1;
    check("no enable", stall, 1'b0);
    tick();
    bnd = 1'b0;
    per.t1_flag = 3'b001;
    #1;
    check("not boundary", stall, 1'b0);
    tick();
    per = '0;
  endtask : t_refuse
  task automatic t_priority();
    logic [15:0] vt [6] = '{VEC_SCI, VEC_SPI, VEC_T2, VEC_T1, VEC_CT, VEC_EXT};
    int n;
    per_en = 1'b1;
    for (int k = 0; k < 6; k++) begin
      per.sci_flag[4] = 1'b1;
      per.sci_en[4] = 1'b1;
      per.spi_flag[1] = (k > 0);
      per.spi_en = 1'b1;
      per.t2_flag[2] = (k > 1);
      per.t2_en[2] = 1'b1;
      per.t1_flag[0] = (k > 2);
      per.t1_en[0] = 1'b1;
      tick_p = (k == 4);
      per.kbd_flag[7] = (k > 4);
      per.keyboard_wakeup_enable[7] = 1'b1;
      tick();
      tick_p = 1'b0;
      strobe(0);
      go(0, n);
      check("vector", regs_o.pc, vpc(vt[k]));
      check("hw time", 16'(n), 16'h0009);
    end
    check("per flag", per_f, 1'b1);
    check("raw pin", pin_lvl, 1'b1);
    per = '0;
    per_clr = 1'b1;
    tick();
    per_clr = 1'b0;
    tick();
    check("per clr", per_f, 1'b0);
  endtask : t_priority
  // Edge mode twice, then level mode with the pin held low
  task automatic t_ext();
    int n;
    for (int i = 0; i < 3; i++) begin
      lvl = (i == 2);
      irq_n = 1'b0;
      repeat (3) tick();
      irq_n = (i != 2);
      strobe(0);
      go(0, n);
      check("ext", regs_o.pc, vpc(VEC_EXT));
      check("ext time", 16'(n), 16'h0009);
    end
    strobe(0);
    go(0, n);
    check("level", regs_o.pc, vpc(VEC_EXT));
    check("level time", 16'(n), 16'h0009);
    irq_n = 1'b1;
    lvl = 1'b0;
    repeat (4) tick();
    strobe(0);
    bnd = 1'b1;
    #1;
    check("ext cleared", stall, 1'b0);
    tick();
    bnd = 1'b0;
  endtask : t_ext
  task automatic t_ovf();
    int n;
    ovf_en = 1'b1;
    cnt = 8'hff;
    tick();
    cnt = 8'h00;
    repeat (2) tick();
    check("ovf flag", ovf_f, 1'b1);
    strobe(0);
    go(0, n);
    check("ovf vec", regs_o.pc, vpc(VEC_CT));
    ovf_clr = 1'b1;
    tick();
    ovf_clr = 1'b0;
    tick();
    check("ovf clr", ovf_f, 1'b0);
  endtask : t_ovf
  // Pin reset, then a system reset, each from a cleared mask
  task automatic t_reset();
    int n;
    for (int k = 0; k < 2; k++) begin
      strobe(0);
      rst_pin_n = (k != 0);
      sys_rst_i = (k != 0);
      repeat (2) tick();
      rst_pin_n = 1'b1;
      sys_rst_i = 1'b0;
      n = 0;
      while (load !== 1'b1 && n < 10) begin
        tick();
        n++;
      end
      check("reset time", 16'(n), 16'h0002);
      check("reset pc", regs_o.pc, vpc(VEC_RESET));
      check("reset mask", mask, 1'b1);
    end
  endtask : t_reset
  initial begin
    int n;
    repeat (3) @(posedge clock_i);
    #10;
    sys_rst_i = 1'b0;
    n = 0;
    while (load !== 1'b1 && n < 10) begin
      tick();
      n++;
    end
    check("reset pc", regs_o.pc, vpc(VEC_RESET));
    check("reset mask", mask, 1'b1);
    t_trap(1'b1);
    strobe(0);
    t_trap(1'b0);
    t_refuse();
    t_priority();
    t_ext();
    t_ovf();
    t_reset();
    conclude();
  end
endmodule : cpu_interrupt_priority_vectoring_test
bind civ_core civ_core_checker u_civ_core_checker (.clock_i, .sys_rst_i, .boundary_i,
  .swi_exec_i, .rti_exec_i, .sp_i, .irq_pin_n_i, .stall_o, .int_mask_o, .mem_o,
  .pc_load_o, .restore_o, .regs_o, .sp_o, .irq_pin_level_o);
